/* File: rtl/bringup_pkg.sv */
package bringup_pkg;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_IDENT = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_SETUP_A = 8'h08;
	localparam logic [7:0] OFS_SETUP_C = 8'h0C;
	localparam logic [7:0] OFS_MASK_A = 8'h10;
	localparam logic [7:0] OFS_MASK_B = 8'h14;
	localparam logic [7:0] OFS_PHY_FLAGS = 8'h18;
	localparam logic [7:0] OFS_FSM_FLAGS = 8'h1C;
	localparam logic [7:0] OFS_SYS = 8'h20;
	localparam logic [7:0] OFS_CTRL = 8'h24;
	localparam logic [7:0] OFS_ADV = 8'h28;
	localparam logic [7:0] OFS_AN_STAT = 8'h2C;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int STAT_RESET_COMPLETE_FLAG = 0;
	localparam int STAT_PHY_IRQ_SUMMARY = 1;
	localparam int SETUP_A_DONE = 15;
	localparam int SYS_READY = 0;
	localparam int SYS_PWRDN = 1;
	localparam int CTRL_PWRDN = 0;
	localparam int CTRL_AN_EN = 1;
	localparam int CTRL_AN_RESTART = 2;
	localparam int ADV_HI_ABL = 0;
	localparam int ADV_HI_REQ = 1;
	localparam int ADV_MASTER = 2;
	localparam int ADV_CAPABLE = 3;
	localparam int AN_DONE = 0;
	localparam int AN_LP_ABL = 1;
	localparam int AN_LP_REQ = 2;
	localparam int AN_LEVEL_HI = 3;
	localparam int PHY_FLAG_AN = 0;
	localparam int FSM_FLAG_RESET = 0;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [31:0] RST_MASK = 32'hFFFF_FFFF;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [4:0] {
		ST_BOOT = 5'h01,
		ST_PWRDN = 5'h02,
		ST_NEGOTIATE = 5'h04,
		ST_LINKED = 5'h08,
		ST_FORCED = 5'h10
	} link_state_e;

	typedef struct packed {
		logic [31:0] dat;
		logic ack;
	} wb_reply_s;

	typedef struct packed {
		logic ability;
		logic request;
	} level_adv_s;

	typedef struct packed {
		link_state_e st;
		wb_reply_s wb;
		logic amp_locked;
		logic reset_complete;
		logic [31:0] setup_a;
		logic [31:0] setup_c;
		logic [31:0] mask_a;
		logic [31:0] mask_b;
		logic [7:0] phy_flags;
		logic [7:0] fsm_flags;
		logic system_ready;
		logic sw_pwrdn;
		logic an_enable;
		level_adv_s local_adv;
		logic adv_master;
		level_adv_s partner_adv;
		logic an_done;
		logic tx_high;
		logic an_active;
		logic irq_n;
	} bringup_s;

endpackage

/* File: rtl/link_bringup.sv */
// What this block does
// - Strap high: no power-down, negotiate at once
// - Strap low: power-down until software release
// - Amplitude strap sets default ability advertisement
// - Role strap sets advertised role preference
// - Sampled straps load control register defaults
// - Identification register returns fixed value
// - Reset-complete flag set after reset
// - Writing one clears flag; interrupt pin goes high once no unmasked summary is pending
// - Summary bit clears when flags cleared or masked
// - Readable system-ready bit after start-up
// - Readable power-down bit, reset value from strap
// - Negotiation enabled out of reset
// - Read-only capability bit gates higher level
// - Local ability bit allowed only when capable
// - Local request bit allowed only when capable
// - Partner bits updated, valid when done
// - Lower level unless both able and requested
// - Higher level when both able, one requests
// - Amplitude strap high locks ability bit
// - Role strap low prefers slave, high master
`timescale 1ns/100ps
`default_nettype none

module link_bringup #(
	parameter logic [31:0] IDENT_VALUE = 32'h0001_2345,
	parameter bit HIGH_LEVEL_CAPABLE = 1'b1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic powerdown_after_reset_strap_i,
	input wire logic tx_amplitude_strap_i,
	input wire logic role_preference_strap_i,
	input wire logic partner_page_i,
	input wire logic partner_adv_high_ability_i,
	input wire logic partner_adv_high_request_i,
	output logic an_active_o,
	output logic tx_high_level_o,
	output logic adv_master_o,
	output logic adv_high_ability_o,
	output logic adv_high_request_o,
	output logic irq_n_o
);

	bringup_pkg::bringup_s q;
	bringup_pkg::bringup_s next_q;

	logic high_level_capable;
	logic req;
	logic wr;
	logic [31:0] wmask;
	logic phy_irq_summary;
	logic [31:0] rdata;

	assign high_level_capable = HIGH_LEVEL_CAPABLE;
	assign req = cyc_i & stb_i;
	// Writes land on the edge where the master sees ack
	assign wr = req & we_i & q.wb.ack;

	genvar b;
	generate
		for (b = 0; b < 4; b++)
		begin : g_lane
			assign wmask[8*b +: 8] = {8{sel_i[b]}};
		end
	endgenerate

	// ----------------------------------------
	// Status summary
	// ----------------------------------------
	// summary follows unmasked flags
	assign phy_irq_summary = |(q.phy_flags & ~q.mask_b[7:0]) |
		|(q.fsm_flags & ~q.mask_b[15:8]);

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always_comb
	begin
		rdata = bringup_pkg::RST_WORD;
		case (adr_i)
			bringup_pkg::OFS_IDENT: rdata = IDENT_VALUE;
			bringup_pkg::OFS_STATUS:
			begin
				rdata[bringup_pkg::STAT_RESET_COMPLETE_FLAG] = q.reset_complete;
				rdata[bringup_pkg::STAT_PHY_IRQ_SUMMARY] = phy_irq_summary;
			end
			bringup_pkg::OFS_SETUP_A: rdata = q.setup_a;
			bringup_pkg::OFS_SETUP_C: rdata = q.setup_c;
			bringup_pkg::OFS_MASK_A: rdata = q.mask_a;
			bringup_pkg::OFS_MASK_B: rdata = q.mask_b;
			bringup_pkg::OFS_PHY_FLAGS: rdata[7:0] = q.phy_flags;
			bringup_pkg::OFS_FSM_FLAGS: rdata[7:0] = q.fsm_flags;
			bringup_pkg::OFS_SYS:
			begin
				rdata[bringup_pkg::SYS_READY] = q.system_ready;
				rdata[bringup_pkg::SYS_PWRDN] = q.sw_pwrdn;
			end
			bringup_pkg::OFS_CTRL:
			begin
				rdata[bringup_pkg::CTRL_PWRDN] = q.sw_pwrdn;
				rdata[bringup_pkg::CTRL_AN_EN] = q.an_enable;
			end
			bringup_pkg::OFS_ADV:
			begin
				rdata[bringup_pkg::ADV_HI_ABL] = q.local_adv.ability;
				rdata[bringup_pkg::ADV_HI_REQ] = q.local_adv.request;
				rdata[bringup_pkg::ADV_MASTER] = q.adv_master;
				rdata[bringup_pkg::ADV_CAPABLE] = high_level_capable;
			end
			bringup_pkg::OFS_AN_STAT:
			begin
				rdata[bringup_pkg::AN_DONE] = q.an_done;
				rdata[bringup_pkg::AN_LP_ABL] = q.partner_adv.ability;
				rdata[bringup_pkg::AN_LP_REQ] = q.partner_adv.request;
				rdata[bringup_pkg::AN_LEVEL_HI] = q.tx_high;
			end
			default: rdata = bringup_pkg::RST_WORD;
		endcase
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		logic restart;
		logic resolved_high;
		restart = 1'b0;
		resolved_high = 1'b0;
		next_q = q;

		// Unmapped addresses still ack and read zero
		next_q.wb.ack = req & ~q.wb.ack;
		// Data only beside ack, so the bus reads zero between answers
		next_q.wb.dat = (req & ~q.wb.ack) ? rdata : bringup_pkg::RST_WORD;

		// Register writes
		if (wr)
		begin
			case (adr_i)
				bringup_pkg::OFS_STATUS:
				begin
					if (sel_i[0] & dat_i[bringup_pkg::STAT_RESET_COMPLETE_FLAG])
					begin
						next_q.reset_complete = 1'b0;
					end
				end
				// host setup order lands here; done bit is plain storage
				bringup_pkg::OFS_SETUP_A:
				begin
					next_q.setup_a = (q.setup_a & ~wmask) | (dat_i & wmask);
				end
				bringup_pkg::OFS_SETUP_C:
				begin
					next_q.setup_c = (q.setup_c & ~wmask) | (dat_i & wmask);
				end
				bringup_pkg::OFS_MASK_A:
				begin
					next_q.mask_a = (q.mask_a & ~wmask) | (dat_i & wmask);
				end
				bringup_pkg::OFS_MASK_B:
				begin
					next_q.mask_b = (q.mask_b & ~wmask) | (dat_i & wmask);
				end
				bringup_pkg::OFS_PHY_FLAGS:
				begin
					next_q.phy_flags = q.phy_flags & ~(dat_i[7:0] & wmask[7:0]);
				end
				bringup_pkg::OFS_FSM_FLAGS:
				begin
					next_q.fsm_flags = q.fsm_flags & ~(dat_i[7:0] & wmask[7:0]);
				end
				bringup_pkg::OFS_CTRL:
				begin
					if (sel_i[0])
					begin
						next_q.sw_pwrdn = dat_i[bringup_pkg::CTRL_PWRDN];
						next_q.an_enable = dat_i[bringup_pkg::CTRL_AN_EN];
						restart = dat_i[bringup_pkg::CTRL_AN_RESTART];
					end
				end
				bringup_pkg::OFS_ADV:
				begin
					if (sel_i[0])
					begin
						if (!q.amp_locked)
						begin
							next_q.local_adv.ability = dat_i[bringup_pkg::ADV_HI_ABL] &
								high_level_capable;
						end
						next_q.local_adv.request = dat_i[bringup_pkg::ADV_HI_REQ] &
							high_level_capable;
						next_q.adv_master = dat_i[bringup_pkg::ADV_MASTER];
					end
				end
				default:
				begin
				end
			endcase
		end

		// lower unless both able and one requests
		// higher when both able and one requests
		resolved_high = q.local_adv.ability & q.partner_adv.ability &
			(q.local_adv.request | q.partner_adv.request);

		next_q.an_active = 1'b0;
		next_q.tx_high = 1'b0;

		case (q.st)
			bringup_pkg::ST_BOOT:
			begin
				// straps load control defaults after release
				next_q.amp_locked = tx_amplitude_strap_i;
				next_q.local_adv.ability = ~tx_amplitude_strap_i & high_level_capable;
				next_q.local_adv.request = 1'b0;
				next_q.adv_master = role_preference_strap_i;
				next_q.sw_pwrdn = ~powerdown_after_reset_strap_i;
				next_q.reset_complete = 1'b1;
				next_q.fsm_flags[bringup_pkg::FSM_FLAG_RESET] = 1'b1;
				next_q.system_ready = 1'b1;
				if (powerdown_after_reset_strap_i)
				begin
					next_q.st = bringup_pkg::ST_NEGOTIATE;
					next_q.an_active = 1'b1;
				end
				else
				begin
					next_q.st = bringup_pkg::ST_PWRDN;
				end
			end
			bringup_pkg::ST_PWRDN:
			begin
				if (!next_q.sw_pwrdn)
				begin
					next_q.st = next_q.an_enable ? bringup_pkg::ST_NEGOTIATE :
						bringup_pkg::ST_FORCED;
					next_q.an_active = next_q.an_enable;
				end
			end
			bringup_pkg::ST_NEGOTIATE:
			begin
				next_q.an_active = 1'b1;
				if (next_q.sw_pwrdn)
				begin
					next_q.st = bringup_pkg::ST_PWRDN;
					next_q.an_active = 1'b0;
				end
				else if (!next_q.an_enable)
				begin
					next_q.st = bringup_pkg::ST_FORCED;
					next_q.an_active = 1'b0;
				end
				else if (partner_page_i)
				begin
					next_q.partner_adv.ability = partner_adv_high_ability_i;
					next_q.partner_adv.request = partner_adv_high_request_i;
					next_q.an_done = 1'b1;
					next_q.phy_flags[bringup_pkg::PHY_FLAG_AN] = 1'b1;
					next_q.st = bringup_pkg::ST_LINKED;
					next_q.an_active = 1'b0;
				end
			end
			bringup_pkg::ST_LINKED:
			begin
				next_q.tx_high = resolved_high;
				if (next_q.sw_pwrdn)
				begin
					next_q.st = bringup_pkg::ST_PWRDN;
					next_q.tx_high = 1'b0;
				end
				else if (!next_q.an_enable)
				begin
					next_q.st = bringup_pkg::ST_FORCED;
					next_q.tx_high = 1'b0;
				end
				else if (restart)
				begin
					next_q.st = bringup_pkg::ST_NEGOTIATE;
					next_q.an_active = 1'b1;
					next_q.tx_high = 1'b0;
				end
			end
			bringup_pkg::ST_FORCED:
			begin
				if (next_q.sw_pwrdn)
				begin
					next_q.st = bringup_pkg::ST_PWRDN;
				end
				else if (next_q.an_enable)
				begin
					next_q.st = bringup_pkg::ST_NEGOTIATE;
					next_q.an_active = 1'b1;
				end
			end
			default:
			begin
				next_q.st = bringup_pkg::ST_BOOT;
			end
		endcase

		// partner bits meaningless once negotiation leaves done
		if (next_q.st != bringup_pkg::ST_LINKED)
		begin
			next_q.an_done = 1'b0;
		end

		// Pin is low while an unmasked event is pending
		// clearing the flag lets the pin return high
		next_q.irq_n = ~((next_q.reset_complete & ~next_q.mask_a[bringup_pkg::STAT_RESET_COMPLETE_FLAG]) |
			(phy_irq_summary & ~next_q.mask_a[bringup_pkg::STAT_PHY_IRQ_SUMMARY]));
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			q <= '0;
			q.st <= bringup_pkg::ST_BOOT;
			q.mask_a <= bringup_pkg::RST_MASK;
			q.mask_b <= bringup_pkg::RST_MASK;
			q.an_enable <= 1'b1;
			q.sw_pwrdn <= 1'b1;
			q.irq_n <= 1'b1;
		end
		else
		begin
			q <= next_q;
		end
	end

	assign dat_o = q.wb.dat;
	assign ack_o = q.wb.ack;
	assign an_active_o = q.an_active;
	assign tx_high_level_o = q.tx_high;
	assign adv_master_o = q.adv_master;
	assign adv_high_ability_o = q.local_adv.ability;
	assign adv_high_request_o = q.local_adv.request;
	assign irq_n_o = q.irq_n;

endmodule

`default_nettype wire

/* File: tb/link_bringup_props.sv */
`timescale 1ns/100ps
`default_nettype none

module link_bringup_props #(
	parameter bit HIGH_LEVEL_CAPABLE = 1'b1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic powerdown_after_reset_strap_i,
	input wire logic tx_amplitude_strap_i,
	input wire logic role_preference_strap_i,
	input wire logic partner_page_i,
	input wire logic partner_adv_high_ability_i,
	input wire logic partner_adv_high_request_i,
	input wire logic an_active_o,
	input wire logic tx_high_level_o,
	input wire logic adv_master_o,
	input wire logic adv_high_ability_o,
	input wire logic adv_high_request_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// ----------------------------------------
	// Sequences and properties
	// ----------------------------------------
	sequence s_req;
		cyc_i && stb_i && !ack_o;
	endsequence
	// Straps are sampled one edge after release and shown one edge later
	sequence s_boot;
		$fell(rst_i) ##2 1'b1;
	endsequence
	sequence s_page;
		an_active_o && partner_page_i;
	endsequence

	property p_ack_next;
		s_req |=> ack_o;
	endproperty
	property p_ack_pulse;
		ack_o |=> !ack_o;
	endproperty
	property p_dat_idle;
		!ack_o |-> dat_o == 32'h0;
	endproperty
	property p_resolve;
		s_page |-> ##2 (tx_high_level_o == ($past(adv_high_ability_o, 2)
			&& $past(partner_adv_high_ability_i, 2)
			&& ($past(adv_high_request_o, 2) || $past(partner_adv_high_request_i, 2))));
	endproperty
	property p_hold_low;
		an_active_o |-> !tx_high_level_o;
	endproperty
	property p_page_drop;
		s_page |=> !an_active_o;
	endproperty
	property p_lock;
		tx_amplitude_strap_i |-> !adv_high_ability_o;
	endproperty
	property p_role;
		s_boot |-> adv_master_o == role_preference_strap_i;
	endproperty
	property p_boot_an;
		s_boot |-> an_active_o == powerdown_after_reset_strap_i;
	endproperty
	property p_ability;
		s_boot |-> adv_high_ability_o == (!tx_amplitude_strap_i && HIGH_LEVEL_CAPABLE);
	endproperty

	a_ack_next: assert property (p_ack_next)
		else $error("ack not one cycle after request");
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("ack longer than one cycle");
	a_dat_idle: assert property (p_dat_idle)
		else $error("read data not zero without ack");
	a_resolve: assert property (p_resolve)
		else $error("resolved level wrong");
	a_hold_low: assert property (p_hold_low)
		else $error("high level while negotiating");
	a_page_drop: assert property (p_page_drop)
		else $error("negotiation not done after page");
	a_lock: assert property (p_lock)
		else $error("ability set with amplitude strap high");
	a_role: assert property (p_role)
		else $error("role preference not from strap");
	a_boot_an: assert property (p_boot_an)
		else $error("start of negotiation not from strap");
	a_ability: assert property (p_ability)
		else $error("ability default not from strap");
endmodule

bind link_bringup link_bringup_props #(.HIGH_LEVEL_CAPABLE(HIGH_LEVEL_CAPABLE)) u_props (
	.clk_i, .rst_i, .cyc_i, .stb_i, .dat_o, .ack_o,
	.powerdown_after_reset_strap_i, .tx_amplitude_strap_i, .role_preference_strap_i,
	.partner_page_i, .partner_adv_high_ability_i, .partner_adv_high_request_i,
	.an_active_o, .tx_high_level_o, .adv_master_o, .adv_high_ability_o, .adv_high_request_o
);

`default_nettype wire

/* File: tb/link_partner_model.sv */
`timescale 1ns/100ps
`default_nettype none

module link_partner_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic an_active_i,
	input wire logic abl_i,
	input wire logic req_i,
	input wire logic [2:0] dly_i,
	output logic page_o,
	output logic abl_o,
	output logic req_o
);
	logic [2:0] wait_cnt;

	always @(posedge clk_i)
	begin
		page_o <= 1'b0;
		if (rst_i)
		begin
			wait_cnt <= 3'h0;
			abl_o <= 1'b0;
			req_o <= 1'b1;
		end
		else if (!an_active_i || page_o)
		begin
			// Bits are meaningless outside a page, so keep them moving
			wait_cnt <= 3'h0;
			abl_o <= ~abl_o;
			req_o <= ~req_o;
		end
		else if (wait_cnt == dly_i)
		begin
			page_o <= 1'b1;
			abl_o <= abl_i;
			req_o <= req_i;
		end
		else
			wait_cnt <= wait_cnt + 3'h1;
	end
endmodule

`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/100ps
`default_nettype none

module testbench;
	// Arbitrary identity value
	localparam logic [31:0] ID_VAL = 32'h0000_A5C3;
	logic clk_i, rst_i, cyc, stb, we, ack_o, pd_s, amp_s, role_s, page, p_abl, p_req;
	logic an_o, tx_o, mst_o, abl_o, req_o, irq_n, m_abl, m_req, e;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, dat_o, seed, x;
	logic [2:0] dly;
	logic [31:0] expq[$];
	int bad_count, checks;
	int cyc_n = 0;

	link_bringup #(.IDENT_VALUE(ID_VAL)) u_link_bringup (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
		.sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
		.powerdown_after_reset_strap_i(pd_s), .tx_amplitude_strap_i(amp_s),
		.role_preference_strap_i(role_s), .partner_page_i(page),
		.partner_adv_high_ability_i(m_abl), .partner_adv_high_request_i(m_req),
		.an_active_o(an_o), .tx_high_level_o(tx_o), .adv_master_o(mst_o),
		.adv_high_ability_o(abl_o), .adv_high_request_o(req_o), .irq_n_o(irq_n)
	);
	link_partner_model u_link_partner_model (
		.clk_i(clk_i), .rst_i(rst_i), .an_active_i(an_o), .abl_i(p_abl), .req_i(p_req),
		.dly_i(dly), .page_o(page), .abl_o(m_abl), .req_o(m_req)
	);

	initial
	begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	// ----------------------------------------
	// Checking and bus tasks
	// ----------------------------------------
	task stop_test;
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task pin(input logic got, input logic exp);
		cmp({31'h0, got}, {31'h0, exp});
	endtask

	// Reads note their expected word; the monitor compares it at ack
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		if (!w)
			expq.push_back(d);
		// Ack is watched mid-cycle so the edge that launches it cannot race
		do @(negedge clk_i); while (ack_o !== 1'b1);
		@(posedge clk_i);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task boot(input logic pd, input logic amp, input logic role);
		rst_i <= 1'b1;
		pd_s <= pd;
		amp_s <= amp;
		role_s <= role;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		@(negedge clk_i);
	endtask

	task settle;
		int n;
		n = 0;
		do @(negedge clk_i); while (an_o !== 1'b1 && n++ < 60);
		do @(negedge clk_i); while (an_o !== 1'b0 && n++ < 60);
		@(negedge clk_i);
	endtask

	always @(negedge clk_i)
		if (ack_o === 1'b1 && we === 1'b0 && expq.size() > 0)
			cmp(dat_o, expq.pop_front());

	always @(posedge clk_i)
	begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 6000)
		begin
			bad_count++;
			stop_test;
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		{cyc, stb, we, adr, wdat, sel} = {3'h0, 8'h00, 32'h0, 4'hF};
		{rst_i, p_abl, p_req, dly} = {3'h4, 3'h0};
		{bad_count, checks} = {32'h0, 32'h0};
		seed = 32'h3393BD19;
		boot(1'b1, 1'b0, 1'b1);
		pin(an_o, 1'b1);
		pin(mst_o, 1'b1);
		pin(abl_o, 1'b1);
		wb(1'b0, bringup_pkg::OFS_IDENT, ID_VAL);
		wb(1'b0, bringup_pkg::OFS_SYS, 32'h1);
		wb(1'b0, bringup_pkg::OFS_ADV, 32'hD);
		wb(1'b0, bringup_pkg::OFS_CTRL, 32'h2);
		wb(1'b0, 8'h30, 32'h0);
		x = $random(seed);
		wb(1'b1, bringup_pkg::OFS_SETUP_C, x);
		wb(1'b0, bringup_pkg::OFS_SETUP_C, x);
		wb(1'b1, bringup_pkg::OFS_SETUP_A, 32'h8000);
		wb(1'b0, bringup_pkg::OFS_SETUP_A, 32'h8000);
		$display("test strap high boot done");
		for (int i = 0; i < 16; i++)
		begin
			{p_req, p_abl} <= i[3:2];
			dly <= 3'($random(seed));
			wb(1'b1, bringup_pkg::OFS_ADV, {30'h0, i[1:0]});
			wb(1'b1, bringup_pkg::OFS_CTRL, 32'h6);
			settle;
			e = i[0] & i[2] & (i[1] | i[3]);
			pin(tx_o, e);
			pin(req_o, i[1]);
			wb(1'b0, bringup_pkg::OFS_AN_STAT, {28'h0, e, i[3], i[2], 1'b1});
		end
		$display("test level resolution done");
		wb(1'b1, bringup_pkg::OFS_MASK_A, 32'h0);
		wb(1'b1, bringup_pkg::OFS_MASK_B, 32'h0);
		wb(1'b0, bringup_pkg::OFS_STATUS, 32'h3);
		pin(irq_n, 1'b0);
		wb(1'b1, bringup_pkg::OFS_STATUS, 32'h1);
		wb(1'b0, bringup_pkg::OFS_STATUS, 32'h2);
		wb(1'b0, bringup_pkg::OFS_SETUP_A, 32'h8000);
		wb(1'b1, bringup_pkg::OFS_MASK_B, 32'hFFFF);
		wb(1'b0, bringup_pkg::OFS_STATUS, 32'h0);
		pin(irq_n, 1'b1);
		$display("test status flags done");
		boot(1'b0, 1'b1, 1'b0);
		pin(an_o, 1'b0);
		pin(mst_o, 1'b0);
		pin(abl_o, 1'b0);
		wb(1'b0, bringup_pkg::OFS_SYS, 32'h3);
		wb(1'b1, bringup_pkg::OFS_ADV, 32'h1);
		wb(1'b0, bringup_pkg::OFS_ADV, 32'h8);
		{p_req, p_abl} <= 2'b11;
		wb(1'b1, bringup_pkg::OFS_CTRL, 32'h2);
		settle;
		pin(tx_o, 1'b0);
		wb(1'b0, bringup_pkg::OFS_AN_STAT, 32'h7);
		$display("test strap low boot done");
		stop_test;
	end
endmodule

`default_nettype wire
